// file: hsf_seq.sv
// Hot swap fault sequencer: flag filters, delay timer, retry counter,
// power good pair and pass switch request, with a Wishbone register port.
// Assumes comparator and strap inputs are asynchronous to clk_i.
module hsf_seq #(
   parameter logic [15:0] FLT_MS_US   = 16'd1000,  // 1.0 ms filters.
   parameter logic [19:0] OC_REG_US   = 20'd3000,  // 3.0 ms window.
   parameter logic [19:0] PG_DLY_US   = 20'd20000, // 20 ms delay.
   parameter logic [9:0]  DLY_DEF_MS  = 10'd200,
   parameter logic [9:0]  DLY_MIN_MS  = 10'd100,
   parameter logic [9:0]  DLY_MAX_MS  = 10'd1000,
   parameter logic [10:0] US_PER_MS   = 11'd1000,
   parameter logic [3:0]  RETRY_MAX   = 4'd10
) (
   input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   input  wire logic                    disable_req_i,
   input  wire logic                    over_temp_i,
   input  wire logic                    upper_voltage_sense_i,
   input  wire logic                    lower_voltage_sense_i,
   input  wire logic                    over_current_i,
   input  wire logic                    enh_full_i,
   input  wire logic                    supply_lockout_ok_i,
   input  wire logic [hsf_pkg::CFG_W-1:0] lower_voltage_cfg_i,
   input  wire logic [hsf_pkg::CFG_W-1:0] run_current_cap_i,
   input  wire logic [hsf_pkg::CFG_W-1:0] charge_current_cap_i,
   input  wire logic [hsf_pkg::CFG_W-1:0] upper_voltage_cfg_i,
   input  wire logic                    wb_cyc_i,
   input  wire logic                    wb_stb_i,
   input  wire logic                    wb_we_i,
   input  wire logic [3:0]              wb_adr_i,
   input  wire logic [3:0]              wb_sel_i,
   input  wire logic [31:0]             wb_dat_i,
   output logic [31:0]                  wb_dat_o,
   output logic                         wb_ack_o,
   output logic                         supply_good_out_o,
   output logic                         supply_good_out_n_o,
   output logic                         pass_on_o
);

   // Registered state and its next value.
   hsf_pkg::hsf_regs_t r_ff;
   hsf_pkg::hsf_regs_t nxt_r;

   // Raw asynchronous inputs.
   logic [hsf_pkg::NSYNC-1:0] raw;

   // Filtered conditions and helpers.
   logic                      dis_raw;
   logic                      ok_all;
   logic                      fault_v;
   logic                      dis_rise;
   logic                      wb_hit;

   // Microsecond filter limit for flag number i.
   function automatic logic [15:0] flt_lim(input int i);
      case (i)
         hsf_pkg::F_OT: flt_lim = hsf_pkg::OT_FLT_US;
         hsf_pkg::F_OC: flt_lim = hsf_pkg::OC_FLT_US;
         default:       flt_lim = FLT_MS_US;
      endcase
   endfunction

   // Current delay in microseconds; 0 selects the default.
   // Out-of-range settings are clamped into the legal span.
   function automatic logic [19:0] dly_us(input logic [9:0] ms);
      logic [9:0]  m;
      logic [31:0] p;
      m = ms;
      p = 32'h0000_0000;
      if (m == 10'h000)
      begin
         m = DLY_DEF_MS;
      end
      else if (m < DLY_MIN_MS)
      begin
         m = DLY_MIN_MS;
      end
      else if (m > DLY_MAX_MS)
      begin
         m = DLY_MAX_MS;
      end
      p = 32'(m) * 32'(US_PER_MS);
      dly_us = p[19:0];
   endfunction

   assign raw = {upper_voltage_cfg_i, charge_current_cap_i,
                 run_current_cap_i, lower_voltage_cfg_i,
                 supply_lockout_ok_i, enh_full_i, over_current_i,
                 lower_voltage_sense_i, upper_voltage_sense_i,
                 over_temp_i, disable_req_i};

   // Outputs come straight from the state register.
   assign wb_dat_o            = r_ff.dat;
   assign wb_ack_o            = r_ff.ack;
   assign supply_good_out_o   = r_ff.good;                      // [R1]
   assign supply_good_out_n_o = ~r_ff.good;                     // [R1]
   assign pass_on_o           = r_ff.pass;

   // Derived conditions from filtered flags and the bus strobe.
   assign ok_all   = ~r_ff.flt[hsf_pkg::F_DIS] & ~r_ff.flt[hsf_pkg::F_OT]
                   & ~r_ff.flt[hsf_pkg::F_OV] & ~r_ff.flt[hsf_pkg::F_UV];
   assign fault_v  = r_ff.flt[hsf_pkg::F_OV] | r_ff.flt[hsf_pkg::F_UV];
   assign dis_rise = r_ff.flt[hsf_pkg::F_DIS] & ~r_ff.dis_q;
   assign wb_hit   = wb_cyc_i & wb_stb_i & ~r_ff.ack;

   // Next-state logic for every register of the block.
   always_comb
   begin
      nxt_r = r_ff;
      dis_raw = 1'b0;

      // Three-stage synchroniser; a change counts once stages two and
      // three agree, so stage one is read by stage two alone.
      nxt_r.s1 = raw;                                            // [R24]
      nxt_r.s2 = r_ff.s1;
      nxt_r.s3 = r_ff.s2;
      for (int b = 0; b < hsf_pkg::NSYNC; b++)
      begin
         if (r_ff.s2[b] == r_ff.s3[b])
         begin
            nxt_r.sq[b] = r_ff.s3[b];
         end
      end

      // Microsecond enable pulse from the clock divider.
      if (r_ff.tick_cnt == 8'(hsf_pkg::TICK_CYC - 1))
      begin
         nxt_r.tick_cnt = 8'h00;
         nxt_r.tick     = 1'b1;
      end
      else
      begin
         nxt_r.tick_cnt = r_ff.tick_cnt + 8'h01;
         nxt_r.tick     = 1'b0;
      end

      // Flag filters: a level must differ for the whole filter time
      // before the filtered copy follows, in both directions.
      for (int i = 0; i < hsf_pkg::NFLT; i++)
      begin
         if (i == hsf_pkg::F_DIS)
         begin
            // The software disable bit joins the pin ahead of the filter.
            dis_raw = r_ff.sq[i] | r_ff.ctrl_dis;              // [R10]
         end
         else
         begin
            dis_raw = r_ff.sq[i];
         end
         if (dis_raw == r_ff.flt[i])
         begin
            nxt_r.fcnt[i] = 16'h0000;
         end
         else if (r_ff.tick)
         begin
            if (r_ff.fcnt[i] + 16'h0001 >= flt_lim(i))
            begin
               nxt_r.flt[i]  = dis_raw;                 // [R10] [R12]
               nxt_r.fcnt[i] = 16'h0000;
            end
            else
            begin
               nxt_r.fcnt[i] = r_ff.fcnt[i] + 16'h0001;
            end
         end
      end
      nxt_r.dis_q = r_ff.flt[hsf_pkg::F_DIS];

      // One timer counts microseconds for every state that waits.
      if (r_ff.tick)
      begin
         nxt_r.tmr = r_ff.tmr + 20'h00001;                     // [R7]
      end

      // Sequencer.
      case (r_ff.st)
         hsf_pkg::S_INIT:
         begin
            // Settings are only taken once the supply is up and the
            // device is not disabled at power application.
            nxt_r.tmr = 20'h00000;
            if (r_ff.sq[hsf_pkg::F_LCK] & ~r_ff.sq[hsf_pkg::F_DIS]
                & ~r_ff.ctrl_dis)                                  // [R14]
            begin
               nxt_r.cfg[3*hsf_pkg::CFG_W-1:0] =
                  r_ff.sq[hsf_pkg::NSYNC-hsf_pkg::CFG_W-1:7];     // [R15]
               nxt_r.st = hsf_pkg::S_CFG;
            end
         end
         hsf_pkg::S_CFG:
         begin
            // The ceiling setting follows after a fixed gap.
            if (r_ff.tmr >= 20'(hsf_pkg::CFG_GAP_US))
            begin
               nxt_r.cfg[4*hsf_pkg::CFG_W-1:3*hsf_pkg::CFG_W] =
                  r_ff.sq[hsf_pkg::NSYNC-1:
                          hsf_pkg::NSYNC-hsf_pkg::CFG_W];          // [R15]
               nxt_r.tmr = 20'h00000;
               nxt_r.st  = hsf_pkg::S_WAIT;
            end
         end
         hsf_pkg::S_WAIT:
         begin
            if (dis_rise & ~r_ff.flt[hsf_pkg::F_OT])
            begin
               // A fresh disable restarts and counts an attempt.
               nxt_r.tmr   = 20'h00000;                         // [R18]
               nxt_r.retry = r_ff.retry + 4'h1;
            end
            else if (r_ff.flt[hsf_pkg::F_OT])
            begin
               // Held heat counts one attempt per timer period.
               if (r_ff.tmr >= dly_us(r_ff.ctrl_tms))
               begin
                  nxt_r.tmr   = 20'h00000;                      // [R18]
                  nxt_r.retry = r_ff.retry + 4'h1;
               end
            end
            else if (!ok_all)
            begin
               // Voltage faults and a held disable wait without counting.
               nxt_r.tmr = 20'h00000;                           // [R17]
            end
            else if (r_ff.tmr >= dly_us(r_ff.ctrl_tms))   // [R6] [R16]
            begin
               nxt_r.tmr  = 20'h00000;
               nxt_r.pass = 1'b1;                               // [R20]
               nxt_r.st   = hsf_pkg::S_RAMP;
            end
            if (nxt_r.retry > RETRY_MAX)
            begin
               nxt_r.pass = 1'b0;                               // [R19]
               nxt_r.st   = hsf_pkg::S_LOCK;
            end
         end
         hsf_pkg::S_LOCK:
         begin
            // Only a new disable request lets attempts resume.
            nxt_r.pass = 1'b0;
            nxt_r.tmr  = 20'h00000;
            if (dis_rise)
            begin
               nxt_r.retry = 4'h0;                        // [R11] [R19]
               nxt_r.st    = hsf_pkg::S_DIS;
            end
         end
         hsf_pkg::S_RAMP, hsf_pkg::S_PGD, hsf_pkg::S_NORM,
         hsf_pkg::S_OCR:
         begin
            if (r_ff.flt[hsf_pkg::F_DIS])
            begin
               nxt_r.pass  = 1'b0;                              // [R2]
               nxt_r.good  = 1'b0;
               nxt_r.retry = 4'h0;                              // [R11]
               nxt_r.st    = hsf_pkg::S_DIS;
            end
            else if (!ok_all)
            begin
               // Leave with switch off; the delay restarts from zero.
               nxt_r.pass = 1'b0;                      // [R3] [R8] [R9]
               nxt_r.good = 1'b0;                               // [R4]
               nxt_r.tmr  = 20'h00000;
               nxt_r.st   = hsf_pkg::S_WAIT;
               if (!fault_v)
               begin
                  nxt_r.retry = r_ff.retry + 4'h1;
               end
            end
            else if (r_ff.st == hsf_pkg::S_RAMP)
            begin
               nxt_r.tmr = 20'h00000;
               if (r_ff.sq[hsf_pkg::F_ENH])
               begin
                  nxt_r.st = hsf_pkg::S_PGD;
               end
            end
            else if (r_ff.st == hsf_pkg::S_PGD)
            begin
               if (r_ff.tmr >= PG_DLY_US)
               begin
                  nxt_r.good  = 1'b1;                           // [R21]
                  nxt_r.retry = 4'h0;
                  nxt_r.st    = hsf_pkg::S_NORM;
               end
            end
            else if (r_ff.st == hsf_pkg::S_NORM)
            begin
               nxt_r.tmr = 20'h00000;
               if (r_ff.flt[hsf_pkg::F_OC])
               begin
                  nxt_r.st = hsf_pkg::S_OCR;                    // [R12]
               end
            end
            else if (!r_ff.flt[hsf_pkg::F_OC])
            begin
               // Overcurrent cleared inside the window.
               nxt_r.st = hsf_pkg::S_NORM;                      // [R22]
            end
            else if (r_ff.tmr >= OC_REG_US)
            begin
               nxt_r.pass  = 1'b0;                        // [R5] [R22]
               nxt_r.good  = 1'b0;
               nxt_r.tmr   = 20'h00000;
               nxt_r.retry = r_ff.retry + 4'h1;
               nxt_r.st    = hsf_pkg::S_WAIT;
            end
         end
         hsf_pkg::S_DIS:
         begin
            // Stay off until the disable is idle past its filter.
            nxt_r.pass  = 1'b0;
            nxt_r.good  = 1'b0;
            nxt_r.tmr   = 20'h00000;
            nxt_r.retry = 4'h0;                                 // [R11]
            if (!r_ff.flt[hsf_pkg::F_DIS])
            begin
               nxt_r.st = hsf_pkg::S_WAIT;                      // [R23]
            end
         end
         default:
         begin
            nxt_r.st = hsf_pkg::S_INIT;
         end
      endcase

      // Wishbone slave: ack one cycle after the strobe.
      nxt_r.ack = wb_hit;
      nxt_r.dat = 32'h0000_0000;
      if (wb_hit && wb_we_i && wb_adr_i == hsf_pkg::A_CTRL)
      begin
         if (wb_sel_i[0])
         begin
            nxt_r.ctrl_dis    = wb_dat_i[hsf_pkg::CTRL_DIS_B];
            nxt_r.ctrl_tms[3:0] = wb_dat_i[hsf_pkg::CTRL_TMS_LO +: 4];
         end
         if (wb_sel_i[1])
         begin
            nxt_r.ctrl_tms[9:4] = wb_dat_i[hsf_pkg::CTRL_TMS_LO+4 +: 6];
         end
      end
      else if (wb_hit && !wb_we_i)
      begin
         case (wb_adr_i)
            hsf_pkg::A_CTRL:
            begin
               nxt_r.dat[hsf_pkg::CTRL_DIS_B]          = r_ff.ctrl_dis;
               nxt_r.dat[hsf_pkg::CTRL_TMS_LO +: 10]   = r_ff.ctrl_tms;
            end
            hsf_pkg::A_STAT:
            begin
               nxt_r.dat[hsf_pkg::ST_RETRY_LO +: 4]    = r_ff.retry;
               nxt_r.dat[hsf_pkg::ST_FLT_LO +: 5]      = r_ff.flt;
               nxt_r.dat[hsf_pkg::ST_PASS_B]           = r_ff.pass;
               nxt_r.dat[hsf_pkg::ST_GOOD_B]           = r_ff.good;
               nxt_r.dat[hsf_pkg::ST_STATE_LO +: 9]    = r_ff.st;
            end
            hsf_pkg::A_CFG:
            begin
               nxt_r.dat[4*hsf_pkg::CFG_W-1:0]         = r_ff.cfg;
            end
            default:
            begin
               nxt_r.dat = 32'h0000_0000;
            end
         endcase
      end
   end

   // State register; reset clears outputs and retries.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         r_ff          <= '0;                                   // [R13]
         r_ff.st       <= hsf_pkg::S_INIT;
         r_ff.ctrl_tms <= hsf_pkg::CTRL_TMS_RST;
      end
      else
      begin
         r_ff <= nxt_r;
      end
   end

endmodule // hsf_seq

// file: hsf_pkg.sv
// Package for the hot swap fault sequencer: constants, state and carriers.
// Assumes a single 125 MHz clock and a classic Wishbone register slave.
// Notes on behaviour
// R1 - Power good pair on only in normal operation and the overcurrent regulation window.
// R2 - Filtered disable drops power good.
// R3 - Over-temperature beyond 12 us drops power good.
// R4 - Voltage window fault beyond 1.0 ms drops it.
// R5 - Overcurrent beyond 3.0 ms drops power good.
// R6 - Delay defaults 200 ms, else 100..1000 ms.
// R7 - One timer serves start-up and retry delay.
// R8 - Filtered overvoltage turns switch off until clear.
// R9 - Filtered undervoltage turns switch off until clear.
// R10 - Host idles line to enable; changes filtered.
// R11 - Disable request clears latched fault state.
// R12 - Overcurrent reported after 100 us above limit.
// R13 - Power-on: switch off, outputs off, retries cleared.
// R14 - Disabled at power-on means no sequence starts.
// R15 - Sample settings; voltage ceiling 128 us later.
// R16 - Delay setting re-read continuously.
// R17 - Voltage faults retry forever without counting.
// R18 - Heat or disable during timer restarts, counts; heat does so only if still present at period end.
// R19 - Stop after 10 retries until disable/power cycle.
// R20 - Turn on after full clean timer period.
// R21 - After enhancement wait, assert, clear retries.
// R22 - Persistent overcurrent: off, restart timer.
// R23 - Disable released: leave disabled, start again.
// R24 - Comparator flags synchronised, delays in clocks.
package hsf_pkg;

   // Timebase: a one-microsecond enable pulse drives every delay.
   localparam int unsigned CLK_HZ   = 125_000_000;
   localparam int unsigned TICK_HZ  = 1_000_000;
   localparam int unsigned TICK_CYC = CLK_HZ / TICK_HZ;

   // Short filter and gap times, microseconds.
   localparam logic [15:0] OT_FLT_US  = 16'h000C; // 12 us.
   localparam logic [15:0] OC_FLT_US  = 16'h0064; // 100 us.
   localparam logic [15:0] CFG_GAP_US = 16'h0080; // 128 us.

   // Flag indices inside the synchroniser vector.
   localparam int F_DIS = 0;
   localparam int F_OT  = 1;
   localparam int F_OV  = 2;
   localparam int F_UV  = 3;
   localparam int F_OC  = 4;
   localparam int F_ENH = 5;
   localparam int F_LCK = 6;
   localparam int NFLT  = 5;
   localparam int CFG_W = 4;
   localparam int NSYNC = 7 + 4 * CFG_W;

   // Register map, byte addresses.
   localparam logic [3:0] A_CTRL = 4'h0;
   localparam logic [3:0] A_STAT = 4'h4;
   localparam logic [3:0] A_CFG  = 4'h8;

   // Control register fields and reset values.
   localparam int CTRL_DIS_B  = 0;
   localparam int CTRL_TMS_LO = 4;
   localparam logic [9:0] CTRL_TMS_RST = 10'h000;

   // Status register field positions.
   localparam int ST_RETRY_LO = 0;
   localparam int ST_FLT_LO   = 4;
   localparam int ST_PASS_B   = 9;
   localparam int ST_GOOD_B   = 10;
   localparam int ST_STATE_LO = 16;

   // Sequencer states, one-hot.
   typedef enum logic [8:0] {
      S_INIT = 9'h001, // Waiting for lockout release and enable.
      S_CFG  = 9'h002, // Gap before the ceiling setting is taken.
      S_WAIT = 9'h004, // Start-up or retry delay running.
      S_LOCK = 9'h008, // Retries exhausted.
      S_RAMP = 9'h010, // Switch on, waiting for full enhancement.
      S_PGD  = 9'h020, // Delay before power good.
      S_NORM = 9'h040, // Normal operation.
      S_OCR  = 9'h080, // Overcurrent regulation window.
      S_DIS  = 9'h100  // Disabled.
   } hsf_state_t;

   // Whole state of the sequencer.
   typedef struct packed {
      hsf_state_t              st;
      logic [NSYNC-1:0]        s1;
      logic [NSYNC-1:0]        s2;
      logic [NSYNC-1:0]        s3;
      logic [NSYNC-1:0]        sq;
      logic [NFLT-1:0]         flt;
      logic [NFLT-1:0][15:0]   fcnt;
      logic [7:0]              tick_cnt;
      logic                    tick;
      logic [19:0]             tmr;
      logic [3:0]              retry;
      logic                    dis_q;
      logic                    ctrl_dis;
      logic [9:0]              ctrl_tms;
      logic [4*CFG_W-1:0]      cfg;
      logic                    ack;
      logic [31:0]             dat;
      logic                    good;
      logic                    pass;
   } hsf_regs_t;

endpackage : hsf_pkg

// file: hsf_seq_asserts.sv
// Checker for hsf_seq: power good, flag filters and bus timing at ports.
// Assumes one clock and a synchronous active-high reset.
module hsf_seq_asserts #(
   parameter logic [15:0] FLT_MS_US = 16'h03E8,  // Slow filter, us.
   parameter logic [19:0] OC_REG_US = 20'h00BB8, // Overload window, us.
   parameter logic [19:0] PG_DLY_US = 20'h04E20  // Power good delay, us.
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic disable_req_i,
   input wire logic over_temp_i,
   input wire logic upper_voltage_sense_i,
   input wire logic lower_voltage_sense_i,
   input wire logic over_current_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic supply_good_out_o,
   input wire logic supply_good_out_n_o,
   input wire logic pass_on_o
);
   // Drop limits allow two ticks (three for overcurrent) of phase and synchroniser slack.
   localparam int TK    = 125;
   localparam int T_FLT = (int'(FLT_MS_US) + 2) * TK + 16;
   localparam int T_OT  = 14 * TK + 16;
   localparam int T_OC  = (int'(OC_REG_US) + 103) * TK + 16;
   localparam int T_PG  = int'(PG_DLY_US) * TK;
   logic [19:0] dis_ff, ot_ff, uv_ff, ov_ff, oc_ff, on_ff; // Run lengths.
   // Saturating run length of a level.
   function automatic logic [19:0] run(logic [19:0] c, logic s);
      return !s ? 20'h00000 : (&c ? c : c + 20'h00001);
   endfunction
   // Counters clear at reset.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         {dis_ff, ot_ff, uv_ff, ov_ff, oc_ff, on_ff} <= '0;
      end
      else
      begin
         dis_ff <= run(dis_ff, disable_req_i);
         ot_ff  <= run(ot_ff, over_temp_i);
         uv_ff  <= run(uv_ff, lower_voltage_sense_i);
         ov_ff  <= run(ov_ff, upper_voltage_sense_i);
         oc_ff  <= run(oc_ff, over_current_i);
         on_ff  <= run(on_ff, pass_on_o);
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_good_pair: assert property (supply_good_out_n_o == !supply_good_out_o)
      else $error("power good outputs not complementary");
   a_good_pass: assert property (supply_good_out_o |-> pass_on_o)
      else $error("power good without switch on");
   a_reset_off: assert property (disable iff (1'b0)
      rst_i |=> !supply_good_out_o && !pass_on_o)
      else $error("outputs active after reset");
   a_dis_drop: assert property (dis_ff > T_FLT |-> !supply_good_out_o)
      else $error("power good kept while disabled");
   a_heat_drop: assert property (ot_ff > T_OT |-> !supply_good_out_o)
      else $error("power good kept while hot");
   a_volt_off: assert property ((uv_ff > T_FLT) || (ov_ff > T_FLT)
      |-> !pass_on_o && !supply_good_out_o)
      else $error("switch kept on with voltage fault");
   a_load_drop: assert property (oc_ff > T_OC |-> !supply_good_out_o)
      else $error("power good kept under overload");
   a_good_delay: assert property ($rose(supply_good_out_o) |-> on_ff >= T_PG)
      else $error("power good before its delay");
   a_ack_once: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus acknowledge not a single pulse");
   cover property ($rose(supply_good_out_o));
   cover property ($fell(pass_on_o));
   cover property (oc_ff > T_OC);
endmodule // hsf_seq_asserts

bind hsf_seq hsf_seq_asserts #(.FLT_MS_US(FLT_MS_US), .OC_REG_US(OC_REG_US),
   .PG_DLY_US(PG_DLY_US)) i_chk (.*);

// file: hsf_load_model.sv
// Switched load model: charges once switched on, may overload.
// Assumes one clock.
module hsf_load_model #(
   parameter int ENH_CYC = 200 // Charge time before full enhancement.
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic pass_on_i,
   input  wire logic overload_i,
   output logic      enh_full_o,
   output logic      over_current_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] chg_ff; // Cycles since the switch closed.
   // An open switch discharges the load.
   always_ff @(posedge clk_i)
   begin
      if (rst_i || !pass_on_i)
      begin
         chg_ff     <= 16'h0000;
         enh_full_o <= 1'b0;
      end
      else if (chg_ff < 16'(ENH_CYC))
      begin
         chg_ff <= chg_ff + 16'h0001;
      end
      else
      begin
         enh_full_o <= 1'b1;
      end
   end
   // Load current only flows through a closed switch.
   assign over_current_o = overload_i && pass_on_i;
endmodule // hsf_load_model

// file: hot_swap_fault_sequencer_bench.sv
// Self-checking bench for hsf_seq with shortened filters and delays.
// Needs the load model and bound checker.
module hot_swap_fault_sequencer_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i = 1'b0, rst_i = 1'b1, dis = 1'b1, ot = 1'b0;
   logic        lock = 1'b0, oload = 1'b0, cyc = 1'b0, stb = 1'b0;
   logic        we = 1'b0, enh, oc, good, good_n, pass, ack;
   logic [1:0]  volt = 2'h0;                        // Bit0 under, bit1 over.
   logic [3:0]  lcfg = 4'h3, ucfg = 4'hA, adr = 4'h0;
   logic [3:0]  rcap = 4'h5, ccap = 4'h9, sel = 4'hF;
   logic [31:0] wdat = 32'h00000000, rdat, q;
   int          errors = 0, comparisons = 0, n;
   always #4 clk_i = ~clk_i; // 125 MHz.
   hsf_seq #(.FLT_MS_US(16'h000A), .OC_REG_US(20'h0001E),
      .PG_DLY_US(20'h0000A), .DLY_MIN_MS(10'h005),
      .US_PER_MS(11'h001)) i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .disable_req_i(dis),
      .over_temp_i(ot), .upper_voltage_sense_i(volt[1]),
      .lower_voltage_sense_i(volt[0]), .over_current_i(oc),
      .enh_full_i(enh), .supply_lockout_ok_i(lock),
      .lower_voltage_cfg_i(lcfg), .run_current_cap_i(rcap),
      .charge_current_cap_i(ccap), .upper_voltage_cfg_i(ucfg),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .supply_good_out_o(good), .supply_good_out_n_o(good_n),
      .pass_on_o(pass));
   hsf_load_model i_load (.clk_i(clk_i), .rst_i(rst_i), .pass_on_i(pass),
      .overload_i(oload), .enh_full_o(enh), .over_current_o(oc));
   function automatic int us(int x);
      return x * 125;
   endfunction
   task automatic close_out();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e,
                      input string m);
      comparisons++;
      if (g !== e)
      begin
         errors++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask
   task automatic hold(input int c);
      repeat (c) @(posedge clk_i);
   endtask
   // Waits until good (s=0) or pass (s=1) is v, bounded.
   task automatic wt(input bit s, input logic v, input int lim,
                     output int k);
      k = 0;
      while ((s ? pass : good) !== v && k < lim)
      begin
         @(posedge clk_i);
         k++;
      end
      if (k >= lim)
      begin
         errors++;
         $display("mismatch at %0t: wait ran out", $time);
         close_out();
      end
   endtask
   // One classic cycle, held until ack is seen high.
   task automatic wb(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] r);
      int k;
      @(posedge clk_i);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      k = 0;
      do
      begin
         @(posedge clk_i);
         k++;
      end
      while (ack !== 1'b1 && k < 16);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      chk(k < 16, 1'b1, "bus answer missing");
   endtask
   initial
   begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      chk({good, good_n, pass}, 3'b010, "outputs after reset");
      lock <= 1'b1;
      hold(us(15));
      chk(pass, 1'b0, "started while disabled");
      wb(1'b0, hsf_pkg::A_STAT, '0, q);
      chk(q[24:16], 9'h001, "idle state while disabled");
      wb(1'b1, hsf_pkg::A_CTRL, 32'h000000A0, q);
      dis <= 1'b0;
      hold(us(20));
      lcfg <= 4'h7;
      ucfg <= 4'hC;
      wt(1, 1'b1, us(200), n);
      chk(n >= us(110), 1'b1, "switch on too early");
      wb(1'b0, hsf_pkg::A_CFG, '0, q);
      chk(q, 32'h0000C953, "sampled straps");
      wt(0, 1'b1, us(30), n);
      chk(good_n, 1'b0, "low power good");
      wb(1'b0, hsf_pkg::A_STAT, '0, q);
      chk(q[3:0], 4'h0, "retries after good");
      wb(1'b0, 4'hC, '0, q);
      chk(q, 32'h00000000, "unmapped read");
      $display("test start-up done");
      ot <= 1'b1;
      hold(us(5));
      ot <= 1'b0;
      hold(us(15));
      chk(good, 1'b1, "short heat dropped good");
      ot <= 1'b1;
      wt(0, 1'b0, us(14), n);
      wb(1'b0, hsf_pkg::A_STAT, '0, q);
      chk(q[3:0], 4'h1, "heat retry");
      ot <= 1'b0;
      wt(0, 1'b1, us(60), n);
      $display("test heat done");
      for (int i = 0; i < 2; i++)
      begin
         volt <= 2'h1 << i;
         wt(1, 1'b0, us(13), n);
         chk(good, 1'b0, "good in voltage fault");
         wb(1'b0, hsf_pkg::A_STAT, '0, q);
         chk(q[3:0], 4'h0, "voltage fault counted");
         volt <= 2'h0;
         wt(0, 1'b1, us(60), n);
      end
      $display("test voltage done");
      oload <= 1'b1;
      wt(0, 1'b0, us(140), n);
      chk(n >= us(128), 1'b1, "overload dropped too soon");
      chk(pass, 1'b0, "switch on after overload");
      oload <= 1'b0;
      wt(0, 1'b1, us(160), n);
      $display("test overload done");
      wb(1'b1, hsf_pkg::A_CTRL, 32'h00000320, q);
      wb(1'b0, hsf_pkg::A_CTRL, '0, q);
      chk(q, 32'h00000320, "delay field");
      dis <= 1'b1;
      wt(0, 1'b0, us(13), n);
      wb(1'b0, hsf_pkg::A_STAT, '0, q);
      chk(q[24:16], 9'h100, "disabled state");
      dis <= 1'b0;
      wt(1, 1'b1, us(75), n);
      chk(n >= us(55), 1'b1, "new delay not used");
      wt(0, 1'b1, us(30), n);
      $display("test disable done");
      wb(1'b1, hsf_pkg::A_CTRL, 32'h00000050, q);
      ot <= 1'b1;
      hold(us(90));
      wb(1'b0, hsf_pkg::A_STAT, '0, q);
      chk(q[24:16], 9'h008, "retries not exhausted");
      ot <= 1'b0;
      hold(us(25));
      chk(pass, 1'b0, "retry after limit");
      dis <= 1'b1;
      hold(us(13));
      wb(1'b0, hsf_pkg::A_STAT, '0, q);
      chk(q[3:0], 4'h0, "retries kept by disable");
      dis <= 1'b0;
      wt(0, 1'b1, us(60), n);
      $display("test retry limit done");
      close_out();
   end
endmodule // hot_swap_fault_sequencer_bench
